// ---- rtl/bre_pkg.sv ----
package bre_pkg;

   // Opcodes presented by the instruction sequencer.
   typedef enum logic [3:0] {
      BRE_OP_NOP          = 4'h0,
      BRE_OP_PUSH         = 4'h1, // push_contact
      BRE_OP_PUSH_INV     = 4'h2, // push_inverted_contact
      BRE_OP_PUSH_WB      = 4'h3, // push_word_bit
      BRE_OP_PUSH_WB_INV  = 4'h4, // push_word_bit_inverted
      BRE_OP_OR           = 4'h5, // parallel contact
      BRE_OP_OR_INV       = 4'h6, // parallel_inverted
      BRE_OP_OR_WB        = 4'h7,
      BRE_OP_OR_WB_INV    = 4'h8,
      BRE_OP_AND          = 4'h9, // series contact
      BRE_OP_AND_INV      = 4'hA, // series_inverted
      BRE_OP_AND_WB       = 4'hB,
      BRE_OP_AND_WB_INV   = 4'hC,
      BRE_OP_COMB_SERIES  = 4'hD, // combine_series
      BRE_OP_MERGE_PAR    = 4'hE, // merge_parallel_branches
      BRE_OP_COIL         = 4'hF  // output coil, mode bit selects wired_or
   } bre_op_t;

   // Point classes of the bit image.
   typedef enum logic [2:0] {
      BRE_SP_INPUT    = 3'h0,
      BRE_SP_OUTPUT   = 3'h1,
      BRE_SP_RELAY    = 3'h2,
      BRE_SP_STAGE    = 3'h3,
      BRE_SP_TIMER    = 3'h4,
      BRE_SP_COUNT    = 3'h5, // count_done_flag
      BRE_SP_SYSFLAG  = 3'h6, // system_flag
      BRE_SP_NONE     = 3'h7
   } bre_space_t;

   localparam int BRE_ADDR_W     = 11;
   localparam int BRE_IMG_AW     = 14;
   localparam int BRE_STACK_LVLS = 8;
   localparam int BRE_DEPTH_W    = 4;
   localparam int BRE_WORD_W     = 16;
   localparam int BRE_BIT_W      = 4;

   // Highest point per class: octal 1777, 3777, 377 and 777.
   localparam logic [BRE_ADDR_W-1:0] BRE_MAX_IO    = 11'h3FF;
   localparam logic [BRE_ADDR_W-1:0] BRE_MAX_RELAY = 11'h7FF;
   localparam logic [BRE_ADDR_W-1:0] BRE_MAX_TC    = 11'h0FF;
   localparam logic [BRE_ADDR_W-1:0] BRE_MAX_SYS   = 11'h1FF;

   // Base of each class in the flat bit image, in 1 Ki-bit pages.
   localparam logic [BRE_IMG_AW-1:0] BRE_BASE_INPUT  = 14'h0000;
   localparam logic [BRE_IMG_AW-1:0] BRE_BASE_OUTPUT = 14'h0400;
   localparam logic [BRE_IMG_AW-1:0] BRE_BASE_RELAY  = 14'h0800;
   localparam logic [BRE_IMG_AW-1:0] BRE_BASE_STAGE  = 14'h1000;
   localparam logic [BRE_IMG_AW-1:0] BRE_BASE_TIMER  = 14'h1400;
   localparam logic [BRE_IMG_AW-1:0] BRE_BASE_COUNT  = 14'h1800;
   localparam logic [BRE_IMG_AW-1:0] BRE_BASE_SYS    = 14'h1C00;

   localparam logic [BRE_STACK_LVLS-1:0] BRE_STACK_RST = 8'h00;
   localparam logic [BRE_DEPTH_W-1:0]    BRE_DEPTH_RST = 4'h0;

   typedef enum logic [1:0] {
      BRE_ST_IDLE  = 2'b00,
      BRE_ST_FETCH = 2'b01,
      BRE_ST_EXEC  = 2'b10
   } bre_state_t;

endpackage

// ---- rtl/bre_bit_image.sv ----
// Bit-addressed image register with a registered read port.
module bre_bit_image
   import bre_pkg::*;
#(
   parameter int AW = BRE_IMG_AW
) (
   input  wire logic          clk_i,   // System clock.
   input  wire logic [AW-1:0] raddr_i, // Read address.
   output logic               rdata_o, // Registered read data.
   input  wire logic          we_i,    // Write strobe.
   input  wire logic [AW-1:0] waddr_i, // Write address.
   input  wire logic          wdata_i  // Write data.
);

   logic mem [0:(1<<AW)-1];

   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      rdata_o <= mem[raddr_i];
   end

endmodule

// ---- rtl/bre_evaluator.sv ----
// What this block does
// [RULE1] push_contact starts a branch equal to the addressed point.
// [RULE2] push_inverted_contact starts a branch with the point's complement.
// [RULE3] Word-bit variants take bit 0 to 15 of an addressed word.
// [RULE4] Inverted word-bit variants use that bit's complement.
// [RULE5] Parallel contact ORs the point into the branch value.
// [RULE6] parallel_inverted ORs the point's complement into the branch.
// [RULE7] Series contact ANDs the point into the branch value.
// [RULE8] series_inverted ANDs the point's complement into the branch.
// [RULE9] combine_series pops two branches and pushes their AND.
// [RULE10] merge_parallel_branches pops two branches and pushes their OR.
// [RULE11] Sequencer joins only branches that began with a start contact.
// [RULE12] Output coil writes the rung value into the addressed point.
// [RULE13] Program should not drive one location from several output coils.
// [RULE14] wired_or_coil ORs the rung value into the addressed output.
// [RULE15] Operands cover io 1777, relays 3777, timers 377, flags 777 octal.
// [RULE16] Branch values sit on an eight-level stack; overflow is an error.
// [RULE17] A start contact pushes on top, moving others down one level.
// [RULE18] Coils use top of stack and leave it unchanged.
// [RULE19] Combining with fewer than two values flags an error.
module bre_evaluator
   import bre_pkg::*;
#(
   parameter int LVLS = BRE_STACK_LVLS
) (
   input  wire logic                  clk_i,      // 25 MHz clock.
   input  wire logic                  rst_i,      // Async reset, high.
   input  wire logic                  rung_i,     // New rung: clear stack.
   input  wire logic                  valid_i,    // Instruction offered.
   output logic                       ready_o,    // Evaluator can take one.
   input  wire logic [3:0]            op_i,       // Opcode.
   input  wire logic [2:0]            space_i,    // Point class.
   input  wire logic [BRE_ADDR_W-1:0] addr_i,     // Point number.
   input  wire logic                  wired_or_i, // Coil mode: wired_or_coil.
   input  wire logic [BRE_WORD_W-1:0] word_i,     // Fetched memory word.
   input  wire logic [BRE_BIT_W-1:0]  bit_sel_i,  // Bit of word.
   output logic                       done_o,     // Instruction retired.
   output logic                       top_o,      // Top of stack value.
   output logic [BRE_DEPTH_W-1:0]     depth_o,    // Stack depth.
   output logic                       err_ovf_o,  // Sticky overflow error.
   output logic                       err_unf_o,  // Sticky underflow error.
   output logic                       err_addr_o  // Sticky range error.
);

   bre_state_t                 state_q;
   bre_op_t                    op_q;
   logic [BRE_IMG_AW-1:0]      iaddr_q;
   logic                       addr_ok_q;
   logic                       wor_q;
   logic                       wbit_q;
   logic [LVLS-1:0]            stk_q;
   logic [BRE_DEPTH_W-1:0]     depth_q;
   logic                       img_rd;
   logic                       img_we;
   logic                       img_wd;
   logic                       contact;
   logic                       inv;
   logic                       wordbit;

   // Maps a class and point number onto the flat image; out-of-range
   // points are reported so a bad operand never aliases another class.
   function automatic logic range_ok(input logic [2:0] sp,
                                     input logic [BRE_ADDR_W-1:0] a);
      case (sp)
         BRE_SP_INPUT, BRE_SP_OUTPUT, BRE_SP_STAGE:
            range_ok = (a <= BRE_MAX_IO); // RULE15
         BRE_SP_RELAY:   range_ok = (a <= BRE_MAX_RELAY); // RULE15
         BRE_SP_TIMER, BRE_SP_COUNT:
            range_ok = (a <= BRE_MAX_TC); // RULE15
         BRE_SP_SYSFLAG: range_ok = (a <= BRE_MAX_SYS); // RULE15
         default:        range_ok = 1'b0;
      endcase
   endfunction

   function automatic logic [BRE_IMG_AW-1:0] img_addr(
      input logic [2:0] sp, input logic [BRE_ADDR_W-1:0] a);
      logic [BRE_IMG_AW-1:0] b;
      case (sp)
         BRE_SP_OUTPUT:  b = BRE_BASE_OUTPUT;
         BRE_SP_RELAY:   b = BRE_BASE_RELAY;
         BRE_SP_STAGE:   b = BRE_BASE_STAGE;
         BRE_SP_TIMER:   b = BRE_BASE_TIMER;
         BRE_SP_COUNT:   b = BRE_BASE_COUNT;
         BRE_SP_SYSFLAG: b = BRE_BASE_SYS;
         default:        b = BRE_BASE_INPUT;
      endcase
      img_addr = b + {{(BRE_IMG_AW-BRE_ADDR_W){1'b0}}, a};
   endfunction

   function automatic logic is_wordbit(input bre_op_t o);
      is_wordbit = (o == BRE_OP_PUSH_WB) || (o == BRE_OP_PUSH_WB_INV) ||
                   (o == BRE_OP_OR_WB)   || (o == BRE_OP_OR_WB_INV)   ||
                   (o == BRE_OP_AND_WB)  || (o == BRE_OP_AND_WB_INV);
   endfunction

   wire logic accept = (state_q == BRE_ST_IDLE) && valid_i;

   bre_bit_image #(
      .AW (BRE_IMG_AW)
   ) u_image (
      .clk_i   (clk_i),
      .raddr_i (iaddr_q),
      .rdata_o (img_rd),
      .we_i    (img_we),
      .waddr_i (iaddr_q),
      .wdata_i (img_wd)
   );

   // Sequencing: point reads need one cycle for the registered image.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= BRE_ST_IDLE;
      end else begin
         case (state_q)
            BRE_ST_IDLE:  if (valid_i) state_q <= BRE_ST_FETCH;
            BRE_ST_FETCH: state_q <= BRE_ST_EXEC;
            BRE_ST_EXEC:  state_q <= BRE_ST_IDLE;
            default:      state_q <= BRE_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         op_q      <= BRE_OP_NOP;
         iaddr_q   <= '0;
         addr_ok_q <= 1'b0;
         wor_q     <= 1'b0;
         wbit_q    <= 1'b0;
      end else if (accept) begin
         op_q      <= bre_op_t'(op_i);
         iaddr_q   <= img_addr(space_i, addr_i);
         addr_ok_q <= range_ok(space_i, addr_i);
         wor_q     <= wired_or_i;
         wbit_q    <= word_i[bit_sel_i]; // RULE3
      end
   end

   always_comb begin
      inv = 1'b0;
      case (op_q)
         BRE_OP_PUSH_INV, BRE_OP_PUSH_WB_INV, BRE_OP_OR_INV,
         BRE_OP_OR_WB_INV, BRE_OP_AND_INV, BRE_OP_AND_WB_INV:
            inv = 1'b1;
         default: inv = 1'b0;
      endcase
   end

   always_comb begin
      wordbit = is_wordbit(op_q);
      // Out-of-range point reads count as an off point, before inversion.
      contact = (wordbit ? wbit_q : (img_rd & addr_ok_q)) ^ inv; // RULE2
   end

   // Coil write: assignment or wired-OR of the top of stack.
   always_comb begin
      img_we = (state_q == BRE_ST_FETCH) && (op_q == BRE_OP_COIL) &&
               addr_ok_q && (depth_q != BRE_DEPTH_RST);
      img_wd = stk_q[0]; // RULE12
      if (wor_q) begin
         img_we = img_we && stk_q[0]; // RULE14
      end
   end

   // Stack: bit 0 is the top, deeper levels in higher bits.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         stk_q   <= BRE_STACK_RST;
         depth_q <= BRE_DEPTH_RST;
      end else if (accept && rung_i) begin
         stk_q   <= BRE_STACK_RST;
         depth_q <= BRE_DEPTH_RST;
      end else if (state_q == BRE_ST_EXEC) begin
         case (op_q)
            BRE_OP_PUSH, BRE_OP_PUSH_INV,
            BRE_OP_PUSH_WB, BRE_OP_PUSH_WB_INV: begin
               // A push past the last level is dropped, not wrapped.
               if (depth_q < BRE_DEPTH_W'(LVLS)) begin // RULE16
                  stk_q   <= {stk_q[LVLS-2:0], contact}; // RULE1 RULE17 RULE4
                  depth_q <= depth_q + 1'b1;
               end
            end
            BRE_OP_OR, BRE_OP_OR_INV, BRE_OP_OR_WB, BRE_OP_OR_WB_INV:
               stk_q[0] <= stk_q[0] | contact; // RULE5 RULE6
            BRE_OP_AND, BRE_OP_AND_INV, BRE_OP_AND_WB, BRE_OP_AND_WB_INV:
               stk_q[0] <= stk_q[0] & contact; // RULE7 RULE8
            BRE_OP_COMB_SERIES: begin
               if (depth_q >= 4'h2) begin // RULE19
                  stk_q   <= {1'b0, stk_q[LVLS-1:2],
                              stk_q[0] & stk_q[1]}; // RULE9
                  depth_q <= depth_q - 1'b1;
               end
            end
            BRE_OP_MERGE_PAR: begin
               if (depth_q >= 4'h2) begin // RULE19
                  stk_q   <= {1'b0, stk_q[LVLS-1:2],
                              stk_q[0] | stk_q[1]}; // RULE10
                  depth_q <= depth_q - 1'b1;
               end
            end
            default: stk_q <= stk_q; // RULE18
         endcase
      end
   end

   // Error flags stay set until reset so software sees any bad rung.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         err_ovf_o  <= 1'b0;
         err_unf_o  <= 1'b0;
         err_addr_o <= 1'b0;
      end else if (state_q == BRE_ST_EXEC) begin
         if ((op_q inside {BRE_OP_PUSH, BRE_OP_PUSH_INV, BRE_OP_PUSH_WB,
                           BRE_OP_PUSH_WB_INV}) &&
             depth_q >= BRE_DEPTH_W'(LVLS)) begin
            err_ovf_o <= 1'b1; // RULE16
         end
         if ((op_q == BRE_OP_COMB_SERIES || op_q == BRE_OP_MERGE_PAR) &&
             depth_q < 4'h2) begin
            err_unf_o <= 1'b1; // RULE19
         end
         if (!wordbit && !addr_ok_q && op_q != BRE_OP_NOP &&
             op_q != BRE_OP_COMB_SERIES && op_q != BRE_OP_MERGE_PAR) begin
            err_addr_o <= 1'b1; // RULE15
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ready_o <= 1'b1;
         done_o  <= 1'b0;
      end else begin
         ready_o <= (state_q == BRE_ST_EXEC) ||
                    (state_q == BRE_ST_IDLE && !valid_i);
         done_o  <= (state_q == BRE_ST_EXEC);
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         top_o   <= 1'b0;
         depth_o <= BRE_DEPTH_RST;
      end else begin
         top_o   <= stk_q[0];
         depth_o <= depth_q;
      end
   end

endmodule

// ---- verification/bre_eval_monitor.sv ----
module bre_eval_monitor
   import bre_pkg::*;
#(
   parameter int LVLS = BRE_STACK_LVLS
) (
   input wire logic                   clk_i,     // Clock.
   input wire logic                   rst_i,     // Reset.
   input wire logic                   rung_i,    // New rung.
   input wire logic                   valid_i,   // Offer.
   input wire logic                   ready_o,   // Ready.
   input wire logic [3:0]             op_i,      // Opcode.
   input wire logic                   done_o,    // Retire.
   input wire logic [BRE_DEPTH_W-1:0] depth_o,   // Depth.
   input wire logic                   err_ovf_o, // Overflow.
   input wire logic                   err_unf_o  // Underflow.
);
   timeunit 1ns;
   timeprecision 1ns;
   logic                   acc;
   logic                   psh;
   logic                   cmb;
   assign acc = ready_o && valid_i && !rung_i;
   assign psh = op_i inside {[4'h1:4'h4]};
   assign cmb = op_i inside {4'hD, 4'hE};
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // The depth seen at the accept edge may still lag the previous retire,
   // so it is read one edge later; the new depth shows one edge after the
   // retire pulse, when $past still holds the old one.
   property p_push;
      acc && psh ##1 depth_o < 4'h8 |->
         ##2 done_o ##1 depth_o == $past(depth_o) + 4'h1;
   endproperty
   a_push: assert property (p_push) else $error("push depth wrong");
   property p_ovf;
      acc && psh ##1 depth_o == 4'h8 |->
         ##2 done_o ##1 err_ovf_o && depth_o == 4'h8;
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow missed");
   property p_comb;
      acc && op_i == 4'hD ##1 depth_o > 4'h1 |->
         ##2 done_o ##1 depth_o == $past(depth_o) - 4'h1;
   endproperty
   a_comb: assert property (p_comb) else $error("series pop wrong");
   property p_merge;
      acc && op_i == 4'hE ##1 depth_o > 4'h1 |->
         ##2 done_o ##1 depth_o == $past(depth_o) - 4'h1;
   endproperty
   a_merge: assert property (p_merge) else $error("merge pop wrong");
   property p_unf;
      acc && cmb ##1 depth_o < 4'h2 |->
         ##2 done_o ##1 err_unf_o && depth_o == $past(depth_o);
   endproperty
   a_unf: assert property (p_unf) else $error("underflow missed");
   property p_coil;
      acc && op_i == 4'hF |-> ##3 done_o ##1 depth_o == $past(depth_o);
   endproperty
   a_coil: assert property (p_coil) else $error("coil moved stack");
   property p_rung;
      ready_o && valid_i && rung_i && psh |-> ##3 done_o ##1 depth_o == 4'h1;
   endproperty
   a_rung: assert property (p_rung) else $error("rung start wrong");
   property p_lvl;
      depth_o <= LVLS;
   endproperty
   a_lvl: assert property (p_lvl) else $error("depth above limit");
   property p_stk;
      err_ovf_o || err_unf_o |=> $stable({err_ovf_o, err_unf_o}) ||
         $rose(err_ovf_o) || $rose(err_unf_o);
   endproperty
   a_stk: assert property (p_stk) else $error("error flag fell");
endmodule

// ---- verification/bre_seq_model.sv ----
module bre_seq_model
   import bre_pkg::*;
(
   input  wire logic                  clk_i,      // Clock.
   input  wire logic                  ready_i,    // Evaluator ready.
   input  wire logic                  done_i,     // Retire pulse.
   output logic                       rung_o,     // New rung.
   output logic                       valid_o,    // Offer.
   output logic [3:0]                 op_o,       // Opcode.
   output logic [2:0]                 space_o,    // Class.
   output logic [BRE_ADDR_W-1:0]      addr_o,     // Point.
   output logic                       wired_or_o, // Coil mode.
   output logic [BRE_WORD_W-1:0]      word_o,     // Word.
   output logic [BRE_BIT_W-1:0]       bit_sel_o   // Bit.
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      valid_o = 1'b0;
      {rung_o, op_o, space_o, addr_o, wired_or_o, word_o, bit_sel_o} = '0;
   end
   // Callers enter just after an edge, so every change lands 1 ns past it.
   task automatic issue(input logic [39:0] f, input int g, output logic ok);
      int n;
      repeat (g) begin
         @(posedge clk_i);
         #1;
      end
      {rung_o, op_o, space_o, addr_o, wired_or_o, word_o, bit_sel_o} = f;
      valid_o = 1'b1;
      n = 0;
      while (!ready_i && n < 20) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      @(posedge clk_i);
      #1;
      valid_o = 1'b0;
      // Idle fields flip so a stale operand can never look valid.
      {rung_o, op_o, space_o, addr_o, wired_or_o, word_o, bit_sel_o} = ~f;
      while (!done_i && n < 20) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      ok = n < 20;
   endtask
endmodule

// ---- verification/tb_top.sv ----
module tb_top;
   import bre_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i, rst_i, rung_i, valid_i, ready_o, wired_or_i, done_o, top_o;
   logic err_ovf_o, err_unf_o, err_addr_o;
   logic [3:0]  op_i, bit_sel_i, depth_o;
   logic [2:0]  space_i;
   logic [10:0] addr_i;
   logic [15:0] word_i;
   int          error_cnt = 0;
   int          checks = 0;
   int          seed = 32'hE477;
   int          d = 0;
   logic        st [8];
   logic        eo = 1'b0, eu = 1'b0, ea = 1'b0;
   logic        img [logic [13:0]];
   logic [2:0]  ps [8] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
   logic [10:0] pa [8] = '{11'h000, 11'h3FF, 11'h3FF, 11'h7FF,
                           11'h3FF, 11'h0FF, 11'h0FF, 11'h1FF};
   bre_evaluator i_bre_evaluator (.clk_i(clk_i), .rst_i(rst_i),
      .rung_i(rung_i), .valid_i(valid_i), .ready_o(ready_o), .op_i(op_i),
      .space_i(space_i), .addr_i(addr_i), .wired_or_i(wired_or_i),
      .word_i(word_i), .bit_sel_i(bit_sel_i), .done_o(done_o),
      .top_o(top_o), .depth_o(depth_o), .err_ovf_o(err_ovf_o),
      .err_unf_o(err_unf_o), .err_addr_o(err_addr_o));
   bre_seq_model i_bre_seq_model (.clk_i(clk_i), .ready_i(ready_o),
      .done_i(done_o), .rung_o(rung_i), .valid_o(valid_i), .op_o(op_i),
      .space_o(space_i), .addr_o(addr_i), .wired_or_o(wired_or_i),
      .word_o(word_i), .bit_sel_o(bit_sel_i));
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   task automatic chk(input string n, input logic [3:0] s,
                      input logic [3:0] e);
      checks++;
      if (s !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   function automatic void mstep(input logic [39:0] f);
      logic rg, wo, c, inv, wb, ok;
      logic [3:0] op, b, pg;
      logic [2:0] sp;
      logic [10:0] a;
      logic [15:0] w;
      logic [13:0] ix;
      {rg, op, sp, a, wo, w, b} = f;
      case (sp)
         3'h2: ok = 1'b1;
         3'h4, 3'h5: ok = a <= 11'h0FF;
         3'h6: ok = a <= 11'h1FF;
         3'h7: ok = 1'b0;
         default: ok = a <= 11'h3FF;
      endcase
      pg = {1'b0, sp} + ((sp > 3'h2) ? 4'h1 : 4'h0);
      ix = {pg, 10'h000} + {3'b000, a};
      wb = op inside {4'h3, 4'h4, 4'h7, 4'h8, 4'hB, 4'hC};
      inv = op inside {4'h2, 4'h4, 4'h6, 4'h8, 4'hA, 4'hC};
      c = wb ? w[b] : (ok ? img[ix] : 1'b0);
      if (!wb && !ok) ea = 1'b1;
      c = c ^ inv;
      if (rg) d = 0;
      if (op >= 4'h1 && op <= 4'h4) begin
         if (d == 8) eo = 1'b1;
         else begin
            st[d] = c;
            d++;
         end
      end else if (op <= 4'h8) st[d-1] = st[d-1] | c;
      else if (op <= 4'hC) st[d-1] = st[d-1] & c;
      else if (op <= 4'hE) begin
         if (d < 2) eu = 1'b1;
         else begin
            d--;
            st[d-1] = op == 4'hD ? st[d-1] & st[d]
                                 : st[d-1] | st[d];
         end
      end else if (ok && d > 0) begin
         if (!wo) img[ix] = st[d-1];
         else if (st[d-1]) img[ix] = 1'b1;
      end
   endfunction
   function automatic logic [39:0] mk(input logic rg, input logic [3:0] op,
      input logic [2:0] sp, input logic [10:0] a, input logic wo,
      input logic [15:0] w, input logic [3:0] b);
      return {rg, op, sp, a, wo, w, b};
   endfunction
   task automatic run(input logic [39:0] f, input int g);
      logic ok;
      i_bre_seq_model.issue(f, g, ok);
      // Depth and top are registered from the stack, so they settle one
      // edge after the retire pulse.
      @(posedge clk_i);
      #1;
      mstep(f);
      chk("done", ok, 4'h1);
      if (d > 0) chk("top", top_o, st[d-1]);
      chk("depth", depth_o, 4'(d));
      chk("errors", {err_ovf_o, err_unf_o, err_addr_o}, {eo, eu, ea});
   endtask
   task automatic print_verdict();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #400000;
      error_cnt++;
      print_verdict();
   end
   initial begin
      int r, w;
      logic [3:0] op;
      rst_i = 1'b1;
      repeat (3) @(posedge clk_i);
      #1;
      chk("reset", {ready_o, done_o, err_ovf_o, top_o}, 4'h8);
      rst_i = 1'b0;
      // Each scan writes every pool point once by assignment, then only
      // wired-OR coils, since a second assigning coil would mask the first.
      for (int s = 0; s < 6; s++) begin
         for (int p = 0; p < 8; p++) begin
            w = $random(seed);
            run(mk(1'b1, 4'h3, 3'h0, 11'h000, 1'b0, w[15:0], w[19:16]), 0);
            run(mk(1'b0, 4'hF, ps[p], pa[p], 1'b0, 16'h0000, 4'h0), 0);
         end
         repeat (40) begin
            r = $random(seed);
            w = $random(seed);
            op = r[3:0];
            if (op == 4'h0 || (d < 2 && op inside {4'hD, 4'hE})) op = 4'h1;
            if (d == 0) op = {2'b00, r[5:4]} + 4'h1;
            else if (d == 8 && op < 4'h5) op = 4'hA;
            run(mk(op < 4'h5 && r[12:10] == 3'h0, op, ps[r[8:6]], pa[r[8:6]],
                   1'b1, w[15:0], w[19:16]), r[13]);
         end
      end
      for (int k = 0; k < 9; k++) run(mk(k == 0, 4'h1, 3'h0, 11'h000, 1'b0,
                                         16'h0000, 4'h0), 0);
      run(mk(1'b1, 4'h2, 3'h0, 11'h400, 1'b0, 16'h0000, 4'h0), 0);
      run(mk(1'b0, 4'hE, 3'h0, 11'h000, 1'b0, 16'h0000, 4'h0), 0);
      run(mk(1'b0, 4'hF, 3'h6, 11'h200, 1'b0, 16'h0000, 4'h0), 0);
      print_verdict();
   end
endmodule
bind bre_evaluator bre_eval_monitor #(.LVLS(LVLS)) i_bre_eval_monitor (
   .clk_i(clk_i), .rst_i(rst_i), .rung_i(rung_i), .valid_i(valid_i),
   .ready_o(ready_o), .op_i(op_i), .done_o(done_o), .depth_o(depth_o),
   .err_ovf_o(err_ovf_o), .err_unf_o(err_unf_o));
